// ===== design/svio_defines.svh
`ifndef SVIO_DEFINES_SVH
`define SVIO_DEFINES_SVH

// Command codes, data numbers and the control key
`define SVIO_CMD_READ 8'h12
`define SVIO_CMD_WRITE_DI 8'h92
`define SVIO_CMD_IO_CTRL 8'h90
`define SVIO_DN_OUT_PINS 8'hC0
`define SVIO_DN_OUT_DEVS 8'h80
`define SVIO_DN_DI_SET 8'h60
`define SVIO_DN_DI_TEST 8'h00
`define SVIO_DN_IN_DIS 8'h00
`define SVIO_DN_IN_EN 8'h10
`define SVIO_DN_OUT_DIS 8'h03
`define SVIO_DN_OUT_EN 8'h13
`define SVIO_KEY 32'h00001EA5

// Output pins
`define SVIO_PIN_COUNT 7
`define SVIO_PIN_PAD 25

// Output device status bits
`define SVIO_OD_READY 0
`define SVIO_OD_SPEED_REACHED 1
`define SVIO_OD_ZERO_SPEED 2
`define SVIO_OD_TORQUE_LIMITING 3
`define SVIO_OD_SPEED_LIMITING 4
`define SVIO_OD_IN_POSITION 5
`define SVIO_OD_WARNING 7
`define SVIO_OD_FAULT 8
`define SVIO_OD_ZERO_PULSE 9
`define SVIO_OD_BRAKE 10
`define SVIO_OD_ALARM_LO 12
`define SVIO_OD_ALARM_HI 14
`define SVIO_OD_BATTERY 15
`define SVIO_OD_GAIN_ACTIVE 25
`define SVIO_OD_ABS_LOST 27

// Input device bits
`define SVIO_DI_SERVO_ON 0
`define SVIO_DI_FWD_STROKE 1
`define SVIO_DI_REV_STROKE 2
`define SVIO_DI_EXT_TQ_SEL 3
`define SVIO_DI_INT_TQ_SEL 4
`define SVIO_DI_PROP_CTRL 5
`define SVIO_DI_FAULT_CLEAR 6
`define SVIO_DI_DROOP_CLEAR 7
`define SVIO_DI_SPEED_A 8
`define SVIO_DI_SPEED_C 10
`define SVIO_DI_FWD_START 11
`define SVIO_DI_REV_START 12
`define SVIO_DI_GEAR_A 13
`define SVIO_DI_GEAR_B 14
`define SVIO_DI_CTRL_SWITCH 15
`define SVIO_DI_ACCEL2 20
`define SVIO_DI_GAIN_CHANGE 27
// Bits 0..15, 20 and 27 carry devices; the rest read as off
`define SVIO_DI_MASK 32'h0810FFFF
`define SVIO_STROKE_MASK 32'h00000006

`define SVIO_WORD_ZERO 32'h00000000

`endif

// ===== design/svio_io_cmd.sv
`timescale 1ns/1ps
`default_nettype none
`include "svio_defines.svh"
module svio_io_cmd #(
	parameter int ANALOG_W = 16
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic cmd_valid_in,
	input wire svio_pkg::svio_byte_t cmd_code_in,
	input wire svio_pkg::svio_byte_t cmd_data_no_in,
	input wire svio_pkg::svio_word_t cmd_data_in,
	input wire logic test_mode_in,
	input wire logic [`SVIO_PIN_COUNT-1:0] output_pins_in,
	input wire logic ready_in,
	input wire logic speed_reached_in,
	input wire logic zero_speed_in,
	input wire logic torque_limiting_in,
	input wire logic speed_limiting_in,
	input wire logic in_position_in,
	input wire logic warning_out_in,
	input wire logic fault_out_in,
	input wire logic encoder_zero_pulse_in,
	input wire logic brake_interlock_in,
	input wire logic [2:0] alarm_code_in,
	input wire logic battery_warning_in,
	input wire logic gain_change_active_in,
	input wire logic abs_position_lost_in,
	input wire svio_pkg::svio_word_t ext_input_devices_in,
	input wire logic emergency_stop_in,
	input wire logic [ANALOG_W-1:0] analog_in,
	input wire logic pulse_train_in,
	output logic reply_valid_out,
	output svio_pkg::svio_word_t reply_data_out,
	output logic reply_error_out,
	output svio_pkg::svio_word_t input_devices_out,
	output logic emergency_stop_out,
	output logic [ANALOG_W-1:0] analog_out,
	output logic pulse_train_out,
	output logic [`SVIO_PIN_COUNT-1:0] output_pins_out,
	output logic inputs_disabled_out,
	output logic outputs_disabled_out
);
	import svio_pkg::*;

	if (ANALOG_W < 1 || ANALOG_W > 32) begin : g_bad_width
		$error("ANALOG_W must lie between 1 and 32");
	end

	svio_status_if st ();
	svio_word_t comm_word;
	svio_word_t next_comm_word;
	svio_word_t next_reply;
	svio_word_t ext_gated;
	svio_word_t next_devices;
	svio_cmd_e cmd_kind;
	logic key_ok;
	logic is_key_cmd;
	logic next_error;
	logic next_in_dis;
	logic next_out_dis;

	assign st.ready = ready_in;
	assign st.speed_reached = speed_reached_in;
	assign st.zero_speed = zero_speed_in;
	assign st.torque_limiting = torque_limiting_in;
	assign st.speed_limiting = speed_limiting_in;
	assign st.in_position = in_position_in;
	assign st.warning_out = warning_out_in;
	assign st.fault_out = fault_out_in;
	assign st.encoder_zero_pulse = encoder_zero_pulse_in;
	assign st.brake_interlock = brake_interlock_in;
	assign st.alarm_code = alarm_code_in;
	assign st.battery_warning = battery_warning_in;
	assign st.gain_change_active = gain_change_active_in;
	assign st.abs_position_lost = abs_position_lost_in;

	svio_status_pack u_pack (
		.st(st.packer)
	);

	// Test-mode write shares data number 00 with input disable, but the
	// command codes differ so the two never collide
	assign cmd_kind =
		(cmd_code_in == `SVIO_CMD_READ &&
		 cmd_data_no_in == `SVIO_DN_OUT_PINS) ? SVIO_RD_PINS :
		(cmd_code_in == `SVIO_CMD_READ &&
		 cmd_data_no_in == `SVIO_DN_OUT_DEVS) ? SVIO_RD_DEVS :
		(cmd_code_in == `SVIO_CMD_WRITE_DI &&
		 cmd_data_no_in == `SVIO_DN_DI_SET) ? SVIO_WR_DI :
		(cmd_code_in == `SVIO_CMD_WRITE_DI && test_mode_in &&
		 cmd_data_no_in == `SVIO_DN_DI_TEST) ? SVIO_WR_DI :
		(cmd_code_in == `SVIO_CMD_IO_CTRL &&
		 cmd_data_no_in == `SVIO_DN_IN_DIS) ? SVIO_IN_DIS :
		(cmd_code_in == `SVIO_CMD_IO_CTRL &&
		 cmd_data_no_in == `SVIO_DN_IN_EN) ? SVIO_IN_EN :
		(cmd_code_in == `SVIO_CMD_IO_CTRL &&
		 cmd_data_no_in == `SVIO_DN_OUT_DIS) ? SVIO_OUT_DIS :
		(cmd_code_in == `SVIO_CMD_IO_CTRL &&
		 cmd_data_no_in == `SVIO_DN_OUT_EN) ? SVIO_OUT_EN : SVIO_BAD;

	assign key_ok = (cmd_data_in == `SVIO_KEY);
	assign is_key_cmd = (cmd_kind == SVIO_IN_DIS) || (cmd_kind == SVIO_IN_EN) ||
		(cmd_kind == SVIO_OUT_DIS) || (cmd_kind == SVIO_OUT_EN);

	always_comb begin
		next_reply = `SVIO_WORD_ZERO;
		next_error = 1'b0;
		next_comm_word = comm_word;
		next_in_dis = inputs_disabled_out;
		next_out_dis = outputs_disabled_out;
		if (cmd_valid_in) begin
			unique case (cmd_kind)
				SVIO_RD_PINS: begin
					next_reply = {{`SVIO_PIN_PAD{1'b0}}, output_pins_out};
				end
				SVIO_RD_DEVS: begin
					next_reply = st.word;
				end
				SVIO_WR_DI: begin
					// Whole word replaces the old one; omitted bits go off
					next_comm_word = cmd_data_in & `SVIO_DI_MASK;
				end
				SVIO_IN_DIS: begin
					next_in_dis = key_ok ? 1'b1 : inputs_disabled_out;
				end
				SVIO_IN_EN: begin
					next_in_dis = key_ok ? 1'b0 : inputs_disabled_out;
				end
				SVIO_OUT_DIS: begin
					next_out_dis = key_ok ? 1'b1 : outputs_disabled_out;
				end
				SVIO_OUT_EN: begin
					next_out_dis = key_ok ? 1'b0 : outputs_disabled_out;
				end
				SVIO_BAD: begin
					next_error = 1'b1;
				end
			endcase
			if (is_key_cmd && !key_ok) begin
				next_error = 1'b1;
			end
		end
	end

	// Stroke ends bypass the disable so a limit switch always stops motion
	assign ext_gated = inputs_disabled_out ?
		(ext_input_devices_in & `SVIO_STROKE_MASK) :
		ext_input_devices_in;
	assign next_devices = (ext_gated | comm_word) & `SVIO_DI_MASK;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			comm_word <= `SVIO_WORD_ZERO;
			inputs_disabled_out <= 1'b0;
			outputs_disabled_out <= 1'b0;
			reply_valid_out <= 1'b0;
			reply_data_out <= `SVIO_WORD_ZERO;
			reply_error_out <= 1'b0;
		end else begin
			comm_word <= next_comm_word;
			inputs_disabled_out <= next_in_dis;
			outputs_disabled_out <= next_out_dis;
			reply_valid_out <= cmd_valid_in;
			reply_data_out <= next_reply;
			reply_error_out <= next_error;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			input_devices_out <= `SVIO_WORD_ZERO;
			emergency_stop_out <= 1'b0;
			analog_out <= '0;
			pulse_train_out <= 1'b0;
			output_pins_out <= '0;
		end else begin
			input_devices_out <= next_devices;
			emergency_stop_out <= emergency_stop_in;
			analog_out <= inputs_disabled_out ? '0 : analog_in;
			pulse_train_out <= inputs_disabled_out ? 1'b0 : pulse_train_in;
			output_pins_out <= outputs_disabled_out ? '0 : output_pins_in;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	a_reply_follows: assert property (
		cmd_valid_in |=> reply_valid_out ##1 !reply_valid_out || $past(cmd_valid_in))
		else $error("reply did not follow command by one cycle");
	a_pin_reply: assert property (
		cmd_valid_in && cmd_kind == SVIO_RD_PINS |=>
		reply_data_out == {{`SVIO_PIN_PAD{1'b0}}, $past(output_pins_out)} &&
		!reply_error_out)
		else $error("pin status reply wrong");
	a_dev_reply: assert property (
		cmd_valid_in && cmd_kind == SVIO_RD_DEVS |=>
		reply_data_out[`SVIO_OD_FAULT] == $past(fault_out_in) &&
		reply_data_out[`SVIO_OD_WARNING] == $past(warning_out_in) &&
		reply_data_out[`SVIO_OD_READY] == $past(ready_in))
		else $error("device status bits misplaced");
	a_alarm_field: assert property (
		cmd_valid_in && cmd_kind == SVIO_RD_DEVS |=>
		reply_data_out[`SVIO_OD_ALARM_HI:`SVIO_OD_ALARM_LO] ==
		$past(alarm_code_in) &&
		reply_data_out[`SVIO_OD_ABS_LOST] == $past(abs_position_lost_in))
		else $error("alarm code field wrong");
	a_word_replace: assert property (
		cmd_valid_in && cmd_kind == SVIO_WR_DI |=>
		comm_word == ($past(cmd_data_in) & `SVIO_DI_MASK) ##1
		input_devices_out[`SVIO_DI_SERVO_ON] ==
		($past(comm_word[`SVIO_DI_SERVO_ON]) |
		($past(ext_gated[`SVIO_DI_SERVO_ON]))))
		else $error("input word not replaced");
	a_test_write: assert property (
		cmd_valid_in && test_mode_in && cmd_code_in == `SVIO_CMD_WRITE_DI &&
		cmd_data_no_in == `SVIO_DN_DI_TEST |=>
		comm_word == ($past(cmd_data_in) & `SVIO_DI_MASK))
		else $error("test mode input word lost");
	a_key_disable: assert property (
		cmd_valid_in && cmd_kind == SVIO_IN_DIS && key_ok |=>
		inputs_disabled_out ##1 analog_out == '0 && !pulse_train_out)
		else $error("input disable did not take effect");
	a_out_disable: assert property (
		cmd_valid_in && cmd_kind == SVIO_OUT_DIS && key_ok |=>
		outputs_disabled_out ##1 output_pins_out == '0)
		else $error("output disable did not take effect");
	a_stroke_pass: assert property (
		inputs_disabled_out && $stable(inputs_disabled_out) |=>
		input_devices_out[`SVIO_DI_FWD_STROKE] ==
		$past(ext_input_devices_in[`SVIO_DI_FWD_STROKE] |
		comm_word[`SVIO_DI_FWD_STROKE]) &&
		emergency_stop_out == $past(emergency_stop_in))
		else $error("stroke end masked by disable");
	a_dis_keeps_word: assert property (
		cmd_valid_in && is_key_cmd |=> $stable(comm_word))
		else $error("disable altered the input word");
	a_bad_key: assert property (
		cmd_valid_in && is_key_cmd && !key_ok |=>
		reply_error_out && $stable(inputs_disabled_out) &&
		$stable(outputs_disabled_out))
		else $error("wrong key was accepted");

	c_dev_read: cover property (cmd_valid_in && cmd_kind == SVIO_RD_DEVS);
	c_dis_then_en: cover property (
		cmd_valid_in && cmd_kind == SVIO_IN_DIS && key_ok ##[1:20]
		cmd_valid_in && cmd_kind == SVIO_IN_EN && key_ok);
	c_bad_key: cover property (cmd_valid_in && is_key_cmd && !key_ok);
	c_test_write: cover property (cmd_valid_in && test_mode_in &&
		cmd_kind == SVIO_WR_DI);
endmodule // svio_io_cmd
`default_nettype wire

// ===== design/svio_pkg.sv
package svio_pkg;
	typedef logic [31:0] svio_word_t;
	typedef logic [7:0] svio_byte_t;
	typedef enum {
		SVIO_RD_PINS,
		SVIO_RD_DEVS,
		SVIO_WR_DI,
		SVIO_IN_DIS,
		SVIO_IN_EN,
		SVIO_OUT_DIS,
		SVIO_OUT_EN,
		SVIO_BAD
	} svio_cmd_e;
endpackage

// ===== design/svio_status_if.sv
`timescale 1ns/1ps
`default_nettype none
interface svio_status_if;
	logic ready;
	logic speed_reached;
	logic zero_speed;
	logic torque_limiting;
	logic speed_limiting;
	logic in_position;
	logic warning_out;
	logic fault_out;
	logic encoder_zero_pulse;
	logic brake_interlock;
	logic [2:0] alarm_code;
	logic battery_warning;
	logic gain_change_active;
	logic abs_position_lost;
	logic [31:0] word;
	modport source (output ready, speed_reached, zero_speed, torque_limiting,
		speed_limiting, in_position, warning_out, fault_out,
		encoder_zero_pulse, brake_interlock, alarm_code, battery_warning,
		gain_change_active, abs_position_lost, input word);
	modport packer (input ready, speed_reached, zero_speed, torque_limiting,
		speed_limiting, in_position, warning_out, fault_out,
		encoder_zero_pulse, brake_interlock, alarm_code, battery_warning,
		gain_change_active, abs_position_lost, output word);
endinterface
`default_nettype wire

// ===== design/svio_status_pack.sv
`timescale 1ns/1ps
`default_nettype none
`include "svio_defines.svh"
module svio_status_pack (
	svio_status_if.packer st
);
	always_comb begin
		st.word = `SVIO_WORD_ZERO;
		st.word[`SVIO_OD_READY] = st.ready;
		st.word[`SVIO_OD_SPEED_REACHED] = st.speed_reached;
		st.word[`SVIO_OD_ZERO_SPEED] = st.zero_speed;
		st.word[`SVIO_OD_TORQUE_LIMITING] = st.torque_limiting;
		st.word[`SVIO_OD_SPEED_LIMITING] = st.speed_limiting;
		st.word[`SVIO_OD_IN_POSITION] = st.in_position;
		st.word[`SVIO_OD_WARNING] = st.warning_out;
		st.word[`SVIO_OD_FAULT] = st.fault_out;
		st.word[`SVIO_OD_ZERO_PULSE] = st.encoder_zero_pulse;
		st.word[`SVIO_OD_BRAKE] = st.brake_interlock;
		st.word[`SVIO_OD_ALARM_HI:`SVIO_OD_ALARM_LO] = st.alarm_code;
		st.word[`SVIO_OD_BATTERY] = st.battery_warning;
		st.word[`SVIO_OD_GAIN_ACTIVE] = st.gain_change_active;
		st.word[`SVIO_OD_ABS_LOST] = st.abs_position_lost;
	end
endmodule // svio_status_pack
`default_nettype wire

// ===== sim/svio_master_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "svio_defines.svh"
module svio_master_model (
	input wire logic clk_in,
	input wire logic reply_valid_in,
	input wire svio_pkg::svio_word_t reply_data_in,
	input wire logic reply_error_in,
	output logic cmd_valid_out,
	output svio_pkg::svio_byte_t cmd_code_out,
	output svio_pkg::svio_byte_t cmd_data_no_out,
	output svio_pkg::svio_word_t cmd_data_out,
	output svio_pkg::svio_word_t ext_out
);
	import svio_pkg::*;
	// Servo on rides in every word so no later word drops it
	svio_word_t keep;
	svio_word_t last_word;
	logic got_valid;
	logic got_error;
	svio_word_t got_data;
	initial begin
		keep = 32'h00000001;
		last_word = `SVIO_WORD_ZERO;
		cmd_valid_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_data_no_out = 8'h00;
		cmd_data_out = `SVIO_WORD_ZERO;
		ext_out = `SVIO_WORD_ZERO;
	end
	// Fields are scrambled once released so stale values never look valid
	task automatic cmd(input svio_byte_t code, input svio_byte_t dn,
			input svio_word_t data);
		@(posedge clk_in);
		cmd_valid_out <= 1'b1;
		cmd_code_out <= code;
		cmd_data_no_out <= dn;
		cmd_data_out <= data;
		@(posedge clk_in);
		cmd_valid_out <= 1'b0;
		cmd_code_out <= ~code;
		cmd_data_no_out <= ~dn;
		cmd_data_out <= ~data;
		#1;
		got_valid = reply_valid_in;
		got_error = reply_error_in;
		got_data = reply_data_in;
	endtask
	task automatic set_ext(input svio_word_t v);
		@(posedge clk_in);
		ext_out <= v;
	endtask
	task automatic write_word(input svio_byte_t dn, input svio_word_t d);
		svio_word_t w;
		w = d | keep;
		@(posedge clk_in);
		// A device commanded off is released at its terminal as well
		ext_out <= ext_out & ~(last_word & ~w);
		last_word = w;
		cmd(`SVIO_CMD_WRITE_DI, dn, w);
	endtask
endmodule // svio_master_model
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "svio_defines.svh"
`define CHECK_EQ(nm, e, g) begin \
	check_count++; \
	if ((e) !== (g)) begin \
		n_fail++; \
		$display("[ERR] %s expected %h seen %h", nm, e, g); \
	end \
end
module tb_top;
	import svio_pkg::*;
	logic clk_in, sys_rst_in, test_mode_in, estop, pulse;
	logic [6:0] pins;
	logic [15:0] analog;
	svio_word_t dv, cmd_data, ext, rep_data, in_devs, comm, r, d;
	logic cmd_valid, rep_valid, rep_error, estop_q, pulse_q;
	svio_byte_t cmd_code, cmd_dn;
	logic [15:0] analog_q;
	logic [6:0] pins_q;
	logic in_dis_q, out_dis_q, in_dis, out_dis, exp_err;
	svio_byte_t ctrl_dn [4];
	int n_fail, check_count, op;
	svio_io_cmd #(.ANALOG_W(16)) uut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
		.cmd_data_no_in(cmd_dn), .cmd_data_in(cmd_data),
		.test_mode_in(test_mode_in), .output_pins_in(pins),
		.ready_in(dv[0]), .speed_reached_in(dv[1]), .zero_speed_in(dv[2]),
		.torque_limiting_in(dv[3]), .speed_limiting_in(dv[4]),
		.in_position_in(dv[5]), .warning_out_in(dv[7]),
		.fault_out_in(dv[8]), .encoder_zero_pulse_in(dv[9]),
		.brake_interlock_in(dv[10]), .alarm_code_in(dv[14:12]),
		.battery_warning_in(dv[15]), .gain_change_active_in(dv[25]),
		.abs_position_lost_in(dv[27]), .ext_input_devices_in(ext),
		.emergency_stop_in(estop), .analog_in(analog),
		.pulse_train_in(pulse), .reply_valid_out(rep_valid),
		.reply_data_out(rep_data), .reply_error_out(rep_error),
		.input_devices_out(in_devs), .emergency_stop_out(estop_q),
		.analog_out(analog_q), .pulse_train_out(pulse_q),
		.output_pins_out(pins_q), .inputs_disabled_out(in_dis_q),
		.outputs_disabled_out(out_dis_q)
	);
	svio_master_model master (
		.clk_in(clk_in), .reply_valid_in(rep_valid),
		.reply_data_in(rep_data), .reply_error_in(rep_error),
		.cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
		.cmd_data_no_out(cmd_dn), .cmd_data_out(cmd_data), .ext_out(ext)
	);
	function automatic svio_word_t exp_dev(input svio_word_t s);
		return s & 32'h0A00F7BF;
	endfunction
	// Stroke ends bypass the disable; communicated bits always apply
	function automatic svio_word_t exp_in(input svio_word_t e,
			input svio_word_t c, input logic dis);
		svio_word_t g;
		g = dis ? (e & 32'h00000006) : e;
		return (g | c) & 32'h0810FFFF;
	endfunction
	task automatic check_reply(input logic e_err, input svio_word_t e_data);
		`CHECK_EQ("reply_valid", 1'b1, master.got_valid)
		`CHECK_EQ("reply_error", e_err, master.got_error)
		`CHECK_EQ("reply_data", e_data, master.got_data)
	endtask
	task automatic check_ports;
		`CHECK_EQ("in_devs", exp_in(ext, comm, in_dis), in_devs)
		`CHECK_EQ("analog", in_dis ? 16'h0000 : analog, analog_q)
		`CHECK_EQ("pulse", in_dis ? 1'b0 : pulse, pulse_q)
		`CHECK_EQ("estop", estop, estop_q)
		`CHECK_EQ("in_dis", in_dis, in_dis_q)
		`CHECK_EQ("out_dis", out_dis, out_dis_q)
		`CHECK_EQ("pins", out_dis ? 7'h00 : pins, pins_q)
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// Guards against a hang at 90000 cycles, far beyond the few hundred the test needs
	initial begin
		#9000000;
		n_fail++;
		finish_test();
	end
	initial begin
		sys_rst_in = 1'b1;
		test_mode_in = 1'b0;
		estop = 1'b0;
		pulse = 1'b0;
		pins = 7'h00;
		analog = 16'h0000;
		dv = `SVIO_WORD_ZERO;
		n_fail = 0;
		check_count = 0;
		in_dis = 1'b0;
		out_dis = 1'b0;
		comm = `SVIO_WORD_ZERO;
		ctrl_dn = '{`SVIO_DN_IN_DIS, `SVIO_DN_IN_EN, `SVIO_DN_OUT_DIS,
			`SVIO_DN_OUT_EN};
		void'($urandom(32'hEAA3));
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		`CHECK_EQ("in_dis", 1'b0, in_dis_q)
		`CHECK_EQ("reply_valid", 1'b0, rep_valid)
		master.cmd(`SVIO_CMD_READ, 8'h55, `SVIO_WORD_ZERO);
		check_reply(1'b1, `SVIO_WORD_ZERO);
		// All on, then all off except servo on: nothing else may linger from the first word
		master.write_word(`SVIO_DN_DI_SET, 32'hFFFFFFFF);
		master.write_word(`SVIO_DN_DI_SET, `SVIO_WORD_ZERO);
		comm = master.keep;
		@(posedge clk_in);
		#1;
		check_ports();
		for (int i = 0; i < 40; i++) begin
			@(posedge clk_in);
			r = $urandom;
			dv <= $urandom;
			pins <= r[6:0];
			analog <= r[22:7];
			pulse <= r[23];
			estop <= r[24];
			test_mode_in <= r[25];
			master.set_ext($urandom);
			op = $urandom_range(6, 0);
			d = $urandom;
			exp_err = 1'b0;
			case (op)
				0, 1, 2, 3: begin
					master.cmd(`SVIO_CMD_IO_CTRL, ctrl_dn[op], `SVIO_KEY);
					if (op < 2) begin
						in_dis = (op == 0);
					end else begin
						out_dis = (op == 2);
					end
				end
				4: begin
					// A single flipped key bit is enough to refuse
					master.cmd(`SVIO_CMD_IO_CTRL, ctrl_dn[r[27:26]],
						`SVIO_KEY ^ (32'h00000001 << d[4:0]));
					exp_err = 1'b1;
				end
				default: begin
					master.write_word(op == 5 ? `SVIO_DN_DI_SET :
						`SVIO_DN_DI_TEST, d);
					exp_err = (op == 6) && !r[25];
					if (!exp_err) begin
						comm = (d | master.keep) & 32'h0810FFFF;
					end
				end
			endcase
			check_reply(exp_err, `SVIO_WORD_ZERO);
			master.cmd(`SVIO_CMD_READ, `SVIO_DN_OUT_PINS, `SVIO_WORD_ZERO);
			check_reply(1'b0, {25'h0, out_dis ? 7'h00 : pins});
			master.cmd(`SVIO_CMD_READ, `SVIO_DN_OUT_DEVS, `SVIO_WORD_ZERO);
			check_reply(1'b0, exp_dev(dv));
			check_ports();
		end
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
